// >>> jesd_align_pkg.sv
package jesd_align_pkg;

	localparam int ADDR_W = 16;
	localparam int DATA_W = 32;
	localparam int LANE_W = 32;

	// register indices; byte address is four times the index
	localparam logic [15:0] IDX_SYSREF_CTRL  = 16'h0120;
	localparam logic [15:0] IDX_SETUP_HOLD   = 16'h0128;
	localparam logic [15:0] IDX_CHIP_SYNC    = 16'h01ff;
	localparam logic [15:0] IDX_PLL_CTRL     = 16'h056e;
	localparam logic [15:0] IDX_LMFC_OFFSET  = 16'h0578;
	localparam logic [15:0] IDX_SUBCLASS     = 16'h0590;
	localparam logic [15:0] IDX_LINK_FRAMING = 16'h0600;
	localparam logic [15:0] IDX_LINK_STATUS  = 16'h0601;

	localparam int SC_LSB       = 5;
	localparam int SR_TRANS_BIT = 4;
	localparam int SR_EDGE_BIT  = 3;
	localparam int CSYNC_BIT    = 0;
	localparam int OFF_W        = 5;
	localparam int MON_SEEN_BIT = 6;
	localparam int MON_MISS_BIT = 7;
	localparam int FR_K_LSB     = 0;
	localparam int FR_F_LSB     = 8;
	localparam int FR_L4_BIT    = 12;
	localparam int FR_D_LSB     = 16;

	localparam logic [7:0]  RST_SUBCLASS    = 8'h20;
	localparam logic [7:0]  RST_SYSREF_CTRL = 8'h00;
	localparam logic [7:0]  RST_CHIP_SYNC   = 8'h00;
	localparam logic [7:0]  RST_PLL_CTRL    = 8'h00;
	localparam logic [7:0]  RST_LMFC_OFFSET = 8'h00;
	localparam logic [31:0] RST_FRAMING     = 32'h0000_101f;
	localparam logic [7:0]  PLL_15G         = 8'h30;
	localparam logic [7:0]  PLL_7G5         = 8'h00;

	localparam int RX_AW = 5;

	typedef enum logic [1:0] {
		F_ONE   = 2'b00,
		F_TWO   = 2'b01,
		F_FOUR  = 2'b10,
		F_EIGHT = 2'b11
	} octets_t;

	typedef enum logic [1:0] {
		RX_HUNT = 2'b00,
		RX_FILL = 2'b01,
		RX_RUN  = 2'b10
	} rx_state_t;

endpackage : jesd_align_pkg

// >>> jesd_link_if.sv
`timescale 1ns/1ps
interface jesd_link_if import jesd_align_pkg::*; ();
	logic              frame_valid;
	logic              mf_start;
	logic              ts_mark;
	logic [LANE_W-1:0] frame_data;

	modport tx (output frame_valid, output mf_start, output ts_mark, output frame_data);
	modport rx (input frame_valid, input mf_start, input ts_mark, input frame_data);
endinterface : jesd_link_if

// >>> jesd_tx_align.sv
// Behaviour
// - subclass field bits 7:5 picks subclass
// - subclass 1 after reset
// - subclass 0: sysref causes no resync (chip sync 1 still stamps), receiver aligns anyway
// - lmfc period starts with each multiframe
// - subclass 1 sysref resyncs lmfc and dividers while chip sync is 0
// - lmfc delayed by five-bit offset in frames
// - one octet: offset in steps of four
// - two octets: offset in steps of two
// - other octet counts: one frame per step
// - readable sysref setup/hold monitor register
// - transition select bit picks sysref transition
// - edge select bit picks capture clock edge
// - chip sync bit picks synchronization method
// - host sets pll control per lane rate
// - receiver buffers from the marker; releases at its lmfc boundary in subclass 1, at the marker in subclass 0
// - four lanes, one octet, k 32 supported
// - decimate-by-8 complex: two or four lanes
// - set bits: falling transition, falling edge
// - chip sync resets 0 normal, 1 timestamp
`timescale 1ns/1ps
module jesd_tx_align import jesd_align_pkg::*; (
	input  wire logic              ref_clk,
	input  wire logic              arst_n,
	input  wire logic [ADDR_W-1:0] address,
	input  wire logic              read,
	input  wire logic              write,
	input  wire logic [DATA_W-1:0] writedata,
	output logic      [DATA_W-1:0] readdata,
	output logic                   waitrequest,
	input  wire logic              sysref,
	input  wire logic [LANE_W-1:0] sample_data,
	output logic                   sample_en,
	output logic                   lmfc_pulse,
	jesd_link_if.tx                link
);

	logic [7:0]        subclass_reg;
	logic [7:0]        sysref_ctrl_reg;
	logic [7:0]        chip_sync_reg;
	logic [7:0]        pll_ctrl_reg;
	logic [7:0]        lmfc_offset_reg;
	logic [31:0]       framing_reg;
	logic [7:0]        monitor_reg;
	logic              sc1_active_reg;
	logic              sr_rise_s1;
	logic              sr_fall_s1;
	logic              sr_rise_s2;
	logic              sr_fall_s2;
	logic              sr_prev_reg;
	logic              sr_sel;
	logic              sr_event;
	logic              resync;
	logic              stamp;
	logic              ts_pend_reg;
	logic [3:0]        div_cnt_reg;
	logic [4:0]        lmfc_cnt_reg;
	logic              frame_tick;
	logic [5:0]        k_len;
	logic [5:0]        off_eff;
	logic [5:0]        phase_load;
	logic              acc;
	logic              rd_acc;
	logic [DATA_W-1:0] rd_mux;

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
		hit = (a == {idx[13:0], 2'b00});
	endfunction : hit

	function automatic logic [5:0] octets(input logic [1:0] code);
		octets = 6'(1) << code;
	endfunction : octets

	// k times f must be a multiple of four
	function automatic logic cfg_ok(input logic [31:0] fr);
		logic [10:0] kf;
		kf = 11'({1'b0, fr[FR_K_LSB +: 5]} + 6'd1) * 11'(octets(fr[FR_F_LSB +: 2]));
		cfg_ok = (kf[1:0] == 2'b00);
	endfunction : cfg_ok

	assign acc    = (read | write) & ~waitrequest;
	assign rd_acc = read & ~waitrequest;
	assign k_len  = {1'b0, framing_reg[FR_K_LSB +: 5]} + 6'd1;

	// bus: one wait cycle, answer at the second edge
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			waitrequest <= 1'b1;
		end else begin
			waitrequest <= ~((read | write) & waitrequest);
		end
	end

	always_comb begin
		rd_mux = '0;
		if (hit(address, IDX_SUBCLASS))
			rd_mux = {24'h0, subclass_reg};
		else if (hit(address, IDX_SYSREF_CTRL))
			rd_mux = {24'h0, sysref_ctrl_reg};
		else if (hit(address, IDX_SETUP_HOLD))
			rd_mux = {24'h0, monitor_reg};
		else if (hit(address, IDX_CHIP_SYNC))
			rd_mux = {24'h0, chip_sync_reg};
		else if (hit(address, IDX_PLL_CTRL))
			rd_mux = {24'h0, pll_ctrl_reg};
		else if (hit(address, IDX_LMFC_OFFSET))
			rd_mux = {24'h0, lmfc_offset_reg};
		else if (hit(address, IDX_LINK_FRAMING))
			rd_mux = framing_reg;
		else if (hit(address, IDX_LINK_STATUS))
			rd_mux = {19'h0, lmfc_cnt_reg, 6'h0, cfg_ok(framing_reg), sc1_active_reg};
	end

	// unmapped reads return zero
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			readdata <= '0;
		end else if (read & waitrequest) begin
			readdata <= rd_mux;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			subclass_reg    <= RST_SUBCLASS;
			sysref_ctrl_reg <= RST_SYSREF_CTRL;
			chip_sync_reg   <= RST_CHIP_SYNC;
			pll_ctrl_reg    <= RST_PLL_CTRL;
			lmfc_offset_reg <= RST_LMFC_OFFSET;
			framing_reg     <= RST_FRAMING;
		end else if (acc & write) begin
			if (hit(address, IDX_SUBCLASS))
				subclass_reg <= writedata[7:0];
			if (hit(address, IDX_SYSREF_CTRL))
				sysref_ctrl_reg <= writedata[7:0];
			if (hit(address, IDX_CHIP_SYNC))
				chip_sync_reg <= writedata[7:0];
			if (hit(address, IDX_PLL_CTRL))
				pll_ctrl_reg <= writedata[7:0];
			if (hit(address, IDX_LMFC_OFFSET))
				lmfc_offset_reg <= writedata[7:0];
			if (hit(address, IDX_LINK_FRAMING))
				framing_reg <= writedata;
		end
	end

	// only codes 0 and 1 switch; others keep the last mode
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sc1_active_reg <= 1'b1;
		end else if (subclass_reg[SC_LSB +: 3] == 3'd0) begin
			sc1_active_reg <= 1'b0;
		end else if (subclass_reg[SC_LSB +: 3] == 3'd1) begin
			sc1_active_reg <= 1'b1;
		end
	end

	// sysref sampled on both edges, each then resynchronised
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sr_rise_s1 <= 1'b0;
		end else begin
			sr_rise_s1 <= sysref;
		end
	end

	always_ff @(negedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sr_fall_s1 <= 1'b0;
		end else begin
			sr_fall_s1 <= sysref;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sr_rise_s2  <= 1'b0;
			sr_fall_s2  <= 1'b0;
			sr_prev_reg <= 1'b0;
		end else begin
			sr_rise_s2  <= sr_rise_s1;
			sr_fall_s2  <= sr_fall_s1;
			sr_prev_reg <= sr_sel;
		end
	end

	assign sr_sel   = sysref_ctrl_reg[SR_EDGE_BIT] ? sr_fall_s2 : sr_rise_s2;
	assign sr_event = sysref_ctrl_reg[SR_TRANS_BIT] ? (sr_prev_reg & ~sr_sel)
		: (~sr_prev_reg & sr_sel);
	// subclass 0 blocks the resync, but with the chip sync bit set sysref still stamps frames
	assign resync = sr_event & sc1_active_reg & ~chip_sync_reg[CSYNC_BIT];
	assign stamp  = sr_event & chip_sync_reg[CSYNC_BIT];

	// offset snapped to the step the octet count allows
	always_comb begin
		unique case (octets_t'(framing_reg[FR_F_LSB +: 2]))
			F_ONE:   off_eff = {1'b0, lmfc_offset_reg[4:2], 2'b00};
			F_TWO:   off_eff = {1'b0, lmfc_offset_reg[4:1], 1'b0};
			F_FOUR,
			F_EIGHT: off_eff = {1'b0, lmfc_offset_reg[OFF_W-1:0]};
		endcase
	end

	// loading k minus offset puts the boundary offset frames late
	always_comb begin
		if (off_eff == 6'd0)
			phase_load = 6'd0;
		else if (off_eff >= k_len)
			phase_load = (off_eff == k_len) ? 6'd0 : 6'(2 * k_len - off_eff);
		else
			phase_load = 6'(k_len - off_eff);
	end

	assign frame_tick = (div_cnt_reg == 4'd0);

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			div_cnt_reg  <= 4'd0;
			lmfc_cnt_reg <= 5'd0;
		end else if (resync) begin
			div_cnt_reg  <= 4'd0;
			lmfc_cnt_reg <= phase_load[4:0];
		end else if (div_cnt_reg >= framing_reg[FR_D_LSB +: 4]) begin
			div_cnt_reg  <= 4'd0;
			lmfc_cnt_reg <= (6'({1'b0, lmfc_cnt_reg} + 6'd1) >= k_len) ? 5'd0
				: 5'(lmfc_cnt_reg + 5'd1);
		end else begin
			div_cnt_reg <= 4'(div_cnt_reg + 4'd1);
		end
	end

	// a stamp on a frame tick is marked at once, so keeping it would mark twice
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ts_pend_reg <= 1'b0;
		end else if (frame_tick) begin
			ts_pend_reg <= 1'b0;
		end else if (stamp) begin
			ts_pend_reg <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sample_en        <= 1'b0;
			lmfc_pulse       <= 1'b0;
			link.frame_valid <= 1'b0;
			link.mf_start    <= 1'b0;
			link.ts_mark     <= 1'b0;
			link.frame_data  <= '0;
		end else begin
			sample_en        <= frame_tick;
			lmfc_pulse       <= frame_tick & (lmfc_cnt_reg == 5'd0);
			link.frame_valid <= frame_tick;
			link.mf_start    <= frame_tick & (lmfc_cnt_reg == 5'd0);
			link.ts_mark     <= frame_tick & (ts_pend_reg | stamp);
			if (frame_tick)
				link.frame_data <= sample_data;
		end
	end

	// monitor: phase of last subclass 1 sysref, and whether any since the last read missed the boundary
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			monitor_reg <= 8'h00;
		end else if (sr_event & sc1_active_reg) begin
			monitor_reg[4:0]          <= lmfc_cnt_reg;
			monitor_reg[MON_SEEN_BIT] <= 1'b1;
			monitor_reg[MON_MISS_BIT] <= monitor_reg[MON_MISS_BIT]
				| (lmfc_cnt_reg != phase_load[4:0]) | ~frame_tick;
		end else if (rd_acc & hit(address, IDX_SETUP_HOLD)) begin
			monitor_reg[MON_SEEN_BIT] <= 1'b0;
			monitor_reg[MON_MISS_BIT] <= 1'b0;
		end
	end

endmodule : jesd_tx_align

// >>> jesd_rx_align.sv
`timescale 1ns/1ps
module jesd_rx_align import jesd_align_pkg::*; (
	input  wire logic              ref_clk,
	input  wire logic              arst_n,
	input  wire logic              sysref,
	input  wire logic              rx_subclass1,
	input  wire logic [4:0]        rx_k_minus1,
	input  wire logic [4:0]        rx_lmfc_offset,
	output logic                   out_valid,
	output logic [LANE_W-1:0]      out_data,
	output logic                   out_ts,
	output logic                   aligned,
	jesd_link_if.rx                link
);

	rx_state_t         state_reg;
	logic [LANE_W:0]   mem [2**RX_AW];
	logic [RX_AW-1:0]  wr_ptr_reg;
	logic [RX_AW-1:0]  rd_ptr_reg;
	logic [4:0]        lmfc_cnt_reg;
	logic              sr_s1;
	logic              sr_s2;
	logic              sr_prev_reg;
	logic              sr_rise;
	logic              wr_en;
	logic              rd_en;

	assign sr_rise = sr_s2 & ~sr_prev_reg & rx_subclass1;
	assign wr_en   = link.frame_valid & ((state_reg != RX_HUNT) | link.mf_start);
	// subclass 0 has no lmfc reference, so release on the marker itself
	assign rd_en   = link.frame_valid & ((state_reg == RX_RUN)
		| ((state_reg == RX_FILL) & (lmfc_cnt_reg == 5'd0))
		| ((state_reg == RX_HUNT) & link.mf_start & ~rx_subclass1));

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sr_s1       <= 1'b0;
			sr_s2       <= 1'b0;
			sr_prev_reg <= 1'b0;
		end else begin
			sr_s1       <= sysref;
			sr_s2       <= sr_s1;
			sr_prev_reg <= sr_s2;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			lmfc_cnt_reg <= 5'd0;
		end else if (sr_rise) begin
			lmfc_cnt_reg <= 5'(5'd0 - rx_lmfc_offset);
		end else if (link.frame_valid) begin
			lmfc_cnt_reg <= (lmfc_cnt_reg >= rx_k_minus1) ? 5'd0 : 5'(lmfc_cnt_reg + 5'd1);
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= RX_HUNT;
		end else if (sr_rise) begin
			state_reg <= RX_HUNT;
		end else begin
			unique case (state_reg)
				RX_HUNT: if (wr_en) state_reg <= rd_en ? RX_RUN : RX_FILL;
				RX_FILL: if (rd_en) state_reg <= RX_RUN;
				RX_RUN:  state_reg <= RX_RUN;
				default: state_reg <= RX_HUNT;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (wr_en)
			mem[wr_ptr_reg] <= {link.ts_mark, link.frame_data};
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			out_valid  <= 1'b0;
			out_data   <= '0;
			out_ts     <= 1'b0;
			aligned    <= 1'b0;
		end else begin
			out_valid <= rd_en;
			aligned   <= (state_reg == RX_RUN) & ~sr_rise;
			if (sr_rise) begin
				wr_ptr_reg <= '0;
				rd_ptr_reg <= '0;
			end else begin
				if (wr_en)
					wr_ptr_reg <= RX_AW'(wr_ptr_reg + 1'b1);
				if (rd_en)
					rd_ptr_reg <= RX_AW'(rd_ptr_reg + 1'b1);
			end
			// reading the word written this cycle bypasses the array
			if (rd_en) begin
				if (rd_ptr_reg == wr_ptr_reg)
					{out_ts, out_data} <= {link.ts_mark, link.frame_data};
				else
					{out_ts, out_data} <= mem[rd_ptr_reg];
			end
		end
	end

endmodule : jesd_rx_align

// >>> jesd_align_props.sv
`timescale 1ns/1ps
module jesd_align_props import jesd_align_pkg::*; (
	input wire logic              ref_clk,
	input wire logic              arst_n,
	input wire logic              frame_valid,
	input wire logic              mf_start,
	input wire logic              ts_mark,
	input wire logic [LANE_W-1:0] frame_data
);
	// a resync may stretch one multiframe to nearly two
	localparam int MF_CYC = 70;
	logic [7:0] gap_reg;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			gap_reg <= 8'h00;
		end else if (mf_start) begin
			gap_reg <= 8'h00;
		end else if (frame_valid) begin
			gap_reg <= gap_reg + 8'h01;
		end
	end

	sequence s_idle_pair;
		!frame_valid [*2];
	endsequence
	sequence s_next_mf;
		##[1:MF_CYC] mf_start;
	endsequence

	property p_mf_on_frame; mf_start |-> frame_valid; endproperty
	property p_ts_on_frame; ts_mark |-> frame_valid; endproperty
	property p_cadence; s_idle_pair |=> frame_valid; endproperty
	property p_reset_frame; $rose(arst_n) |=> frame_valid; endproperty
	property p_first_mf; $rose(arst_n) |-> s_next_mf; endproperty
	property p_mf_period; mf_start |-> s_next_mf; endproperty
	property p_mf_gap; gap_reg < 8'h40; endproperty
	property p_data_on_frame; $changed(frame_data) |-> frame_valid; endproperty

	a_mf_on_frame:
		assert property (p_mf_on_frame) else $error("multiframe start off a frame");
	a_ts_on_frame:
		assert property (p_ts_on_frame) else $error("timestamp off a frame");
	a_cadence:
		assert property (p_cadence) else $error("frame cadence broken");
	a_reset_frame:
		assert property (p_reset_frame) else $error("no frame after reset");
	a_first_mf:
		assert property (p_first_mf) else $error("no multiframe after reset");
	a_mf_period:
		assert property (p_mf_period) else $error("multiframe start missing");
	a_mf_gap:
		assert property (p_mf_gap) else $error("multiframe too long");
	a_data_on_frame:
		assert property (p_data_on_frame) else $error("lane data moved off a frame");
endmodule : jesd_align_props

// >>> jesd_subclass_lmfc_alignment_bench.sv
`timescale 1ns/1ps
module jesd_subclass_lmfc_alignment_bench import jesd_align_pkg::*; ();
	typedef struct packed {
		logic [15:0] idx;
		logic        wr;
		logic [31:0] data;
		logic [31:0] mask;
	} row_t;
	localparam logic [31:0] SAMPLE = 32'h5a3c_0f96;
	localparam int NO_SYNC = 20; // k less the twelve-cycle lead
	localparam int SYNC_LAT = 5; // two sync flops, edge detect, load, output flop
	logic              ref_clk = 1'b0;
	logic              arst_n = 1'b0;
	logic [ADDR_W-1:0] address = '0;
	logic              read = 1'b0;
	logic              write = 1'b0;
	logic [DATA_W-1:0] writedata = '0;
	logic [DATA_W-1:0] readdata;
	logic              waitrequest;
	logic              sysref = 1'b0;
	logic              rx_subclass1 = 1'b1;
	logic              out_valid;
	logic [LANE_W-1:0] out_data;
	logic              aligned;
	logic              sample_en;
	logic              lmfc_pulse;
	int                ts_count = 0;
	int                ts_base;
	logic [31:0]       rd;
	int                n_errors = 0;
	int                cmp_count = 0;
	int                t0;
	int                n;
	int                off_tab [6][3] = '{'{0, 5, 4}, '{0, 8, 8}, '{1, 5, 4},
		'{1, 6, 6}, '{2, 5, 5}, '{2, 3, 3}};
	row_t              rows [17] = '{
		'{IDX_SUBCLASS, 1'b0, 32'h20, 32'hff},
		'{IDX_CHIP_SYNC, 1'b0, 32'h00, 32'hff},
		'{IDX_LINK_FRAMING, 1'b0, 32'h101f, 32'hffff_ffff},
		'{IDX_SETUP_HOLD, 1'b1, 32'hff, 32'h0},
		'{IDX_SETUP_HOLD, 1'b0, 32'h00, 32'hff},
		'{IDX_LINK_STATUS, 1'b0, 32'h03, 32'h03},
		'{IDX_PLL_CTRL, 1'b1, 32'h30, 32'h0},
		'{IDX_PLL_CTRL, 1'b0, 32'h30, 32'hff},
		'{IDX_SUBCLASS, 1'b1, 32'h60, 32'h0},
		'{IDX_LINK_STATUS, 1'b0, 32'h01, 32'h01},
		'{IDX_SUBCLASS, 1'b1, 32'h00, 32'h0},
		'{IDX_LINK_STATUS, 1'b0, 32'h00, 32'h01},
		'{IDX_SUBCLASS, 1'b1, 32'h60, 32'h0},
		'{IDX_LINK_STATUS, 1'b0, 32'h00, 32'h01},
		'{16'h0700, 1'b1, 32'h5a, 32'h0},
		'{16'h0700, 1'b0, 32'h00, 32'hffff_ffff},
		'{IDX_SUBCLASS, 1'b1, 32'h20, 32'h0}};

	jesd_link_if jesd_link_if_inst ();
	jesd_tx_align jesd_tx_align_inst (
		.ref_clk(ref_clk), .arst_n(arst_n), .address(address), .read(read),
		.write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .sysref(sysref), .sample_data(SAMPLE),
		.sample_en(sample_en), .lmfc_pulse(lmfc_pulse), .link(jesd_link_if_inst));
	jesd_rx_align jesd_rx_align_inst (
		.ref_clk(ref_clk), .arst_n(arst_n), .sysref(sysref),
		.rx_subclass1(rx_subclass1), .rx_k_minus1(5'h1f), .rx_lmfc_offset(5'h00),
		.out_valid(out_valid), .out_data(out_data), .out_ts(), .aligned(aligned),
		.link(jesd_link_if_inst));
	jesd_align_props jesd_align_props_inst (
		.ref_clk(ref_clk), .arst_n(arst_n),
		.frame_valid(jesd_link_if_inst.frame_valid), .mf_start(jesd_link_if_inst.mf_start),
		.ts_mark(jesd_link_if_inst.ts_mark), .frame_data(jesd_link_if_inst.frame_data));

	always #20 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		if (jesd_link_if_inst.ts_mark === 1'b1) begin
			ts_count <= ts_count + 1;
		end
	end

	task automatic final_report();
		if (n_errors == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : final_report

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] mask);
		cmp_count++;
		if ((got & mask) !== (exp & mask)) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic bus(input logic [15:0] idx, input logic wr, input logic [31:0] wd);
		int k;
		k = 0;
		@(posedge ref_clk);
		address   <= {idx[13:0], 2'b00};
		read      <= ~wr;
		write     <= wr;
		writedata <= wd;
		do begin
			@(posedge ref_clk);
			k++;
		end while (waitrequest !== 1'b0 && k < 20);
		rd = readdata;
		read  <= 1'b0;
		write <= 1'b0;
		if (k >= 20) begin
			n_errors++;
			final_report();
		end
	endtask : bus

	task automatic wait_mf(output int c);
		c = 0;
		do begin
			@(posedge ref_clk);
			c++;
		end while (jesd_link_if_inst.mf_start !== 1'b1 && c < 80);
		if (c >= 80) begin
			n_errors++;
			final_report();
		end
	endtask : wait_mf

	// lead of twelve cycles keeps a stray resync out of the count
	task automatic measure(input logic lvl, output int c);
		sysref <= ~lvl;
		wait_mf(c);
		repeat (12) @(posedge ref_clk);
		sysref <= lvl;
		wait_mf(c);
	endtask : measure

	task automatic rx_check(input int lim);
		int c;
		c = 0;
		do begin
			@(posedge ref_clk);
			c++;
		end while (!(aligned === 1'b1 && out_valid === 1'b1) && c < lim);
		chk({31'h0, aligned}, 32'h1, 32'h1);
		chk(out_data, SAMPLE, '1);
	endtask : rx_check

	initial begin
		repeat (12) @(posedge ref_clk);
		arst_n <= 1'b1;
		foreach (rows[i]) begin
			bus(rows[i].idx, rows[i].wr, rows[i].data);
			if (!rows[i].wr) begin
				chk(rd, rows[i].data, rows[i].mask);
			end
		end
		measure(1'b1, t0);
		chk({30'h0, sample_en, lmfc_pulse}, 32'h3, '1);
		chk(32'(t0), 32'(SYNC_LAT), '1);
		bus(IDX_SETUP_HOLD, 1'b0, 32'h0);
		chk(rd, 32'h40, 32'h40);
		bus(IDX_SETUP_HOLD, 1'b0, 32'h0);
		chk(rd, 32'h0, 32'h40);
		rx_check(300);
		foreach (off_tab[i]) begin
			bus(IDX_LINK_FRAMING, 1'b1, 32'h0000_101f | (32'(off_tab[i][0]) << 8));
			bus(IDX_LMFC_OFFSET, 1'b1, 32'(off_tab[i][1]));
			measure(1'b1, n);
			chk(32'(n), 32'(t0 + off_tab[i][2]), '1);
		end
		// divide by two: one frame every second cycle
		bus(IDX_LINK_FRAMING, 1'b1, 32'h0001_101f);
		repeat (2) @(posedge ref_clk);
		n = 0;
		repeat (8) begin
			@(posedge ref_clk);
			n += int'(sample_en);
		end
		chk(32'(n), 32'h4, '1);
		bus(IDX_LINK_FRAMING, 1'b1, 32'h0000_101f);
		bus(IDX_LMFC_OFFSET, 1'b1, 32'h0);
		bus(IDX_SYSREF_CTRL, 1'b1, 32'h10);
		measure(1'b0, n);
		chk(32'(n), 32'(t0), '1);
		bus(IDX_SYSREF_CTRL, 1'b1, 32'h18);
		measure(1'b0, n);
		chk(32'(n >= t0 - 1 && n <= t0 + 1), 32'h1, '1);
		bus(IDX_SYSREF_CTRL, 1'b1, 32'h0);
		// mid-run reset; a subclass 0 receiver locks on the first marker
		arst_n       <= 1'b0;
		rx_subclass1 <= 1'b0;
		repeat (2) @(posedge ref_clk);
		arst_n <= 1'b1;
		rx_check(8);
		bus(IDX_SUBCLASS, 1'b0, 32'h0);
		chk(rd, 32'h20, 32'hff);
		bus(IDX_SUBCLASS, 1'b1, 32'h0);
		measure(1'b1, n);
		chk(32'(n), 32'(NO_SYNC), '1);
		rx_check(300);
		bus(IDX_SUBCLASS, 1'b1, 32'h20);
		rx_subclass1 <= 1'b1;
		bus(IDX_CHIP_SYNC, 1'b1, 32'h1);
		ts_base = ts_count;
		measure(1'b1, n);
		chk(32'(n), 32'(NO_SYNC), '1);
		repeat (4) @(posedge ref_clk);
		chk(32'(ts_count - ts_base), 32'h1, '1);
		final_report();
	end
endmodule : jesd_subclass_lmfc_alignment_bench
